// [rtl/asstx_pkg.sv]
// Constants for the asynchronous serial transmitter and receiver core.
// Assumes an APB master on pclk and a software-owned baud divider.
//
// Contract
// - Flags clear by hardware or status-then-data access.
// - Long-word read clears receive flags, not transmit.
// - Flag set after status read survives data access.
// - Either status byte read arms whole register.
// - Data reads give receive holding, writes transmit.
// - Ninth data bit only matters in 9-bit mode.
// - Pin 7 is GPIO unless transmitter enabled.
// - Four enables gate the four flag requests.
// - Start needs three one samples then fall.
// - Idle is all ones, break all zeros.
// - Length bit picks 10- or 11-bit frames.
// - Data bits shift least significant first.
// - Parity select: clear even, set odd.
// - Parity in top data bit; errors flagged.
// - Width from length and parity enable settings.
// - Transmitter holding register is double-buffered.
// - Shifter drives pin until frame in flight ends; the code keeps only the level, and pin7_oe then follows the direction bit.
// - Open-drain select applies to serial and GPIO.
// - Empty flag clear while holding data waits.
// - Data written without clearing empty is dropped.
// - Done flag sets after shifting, clears by sequence.
// - Direction bit rules pin only while disabled.

package asstx_pkg;

	// ==========================================================
	// Register byte addresses.
	localparam logic [11:0] ADDR_BAUD   = 12'h000;
	localparam logic [11:0] ADDR_CTRL   = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_DATA   = 12'h00C;
	localparam logic [11:0] ADDR_PORT   = 12'h010;

	// ==========================================================
	// Control register fields.
	localparam int CTRL_RX_EN   = 0;
	localparam int CTRL_TX_EN   = 1;
	localparam int CTRL_LIE     = 2;
	localparam int CTRL_RIE     = 3;
	localparam int CTRL_TX_DONE_IRQ_EN    = 4;
	localparam int CTRL_TIE     = 5;
	localparam int CTRL_PE      = 6;
	localparam int CTRL_PODD    = 7;
	localparam int CTRL_LEN     = 8;
	localparam int CTRL_OD      = 9;
	localparam int CTRL_BRK     = 10;
	localparam int CTRL_W       = 11;

	// ==========================================================
	// Status register fields.
	localparam int ST_PF    = 0;
	localparam int ST_FE    = 1;
	localparam int ST_OR    = 2;
	localparam int ST_IDLE  = 3;
	localparam int ST_RX_HOLDING_FULL  = 4;
	localparam int ST_TC    = 5;
	localparam int ST_TX_HOLDING_EMPTY  = 6;
	localparam int ST_W     = 7;
	localparam logic [6:0] ST_RX_MASK = 7'h1F;

	// ==========================================================
	// Port register fields: data out bit 0, direction bit 1.
	localparam int PORT_DOUT = 0;
	localparam int PORT_DIR  = 1;

	// ==========================================================
	// Reset values and timing.
	localparam logic [12:0] BAUD_RESET = 13'h0004;
	localparam logic [3:0]  OVERSAMPLE = 4'hF;
	localparam logic [3:0]  MID_SAMPLE = 4'h7;
	localparam logic [1:0]  START_ONES = 2'h3;

	typedef enum logic [1:0] {ASSTX_TX_IDLE, ASSTX_TX_SHIFT}
		asstx_tx_state_t;
	typedef enum logic [1:0] {ASSTX_RX_HUNT, ASSTX_RX_START,
		ASSTX_RX_DATA} asstx_rx_state_t;

endpackage : asstx_pkg

// [rtl/asstx_core.sv]
// Asynchronous serial transmitter and receiver with APB registers.
// Assumes rxd and the pin-7 input are synchronous to pclk.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps

module asstx_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd,
	input  wire logic        pin7_i,
	output logic             pin7_o,
	output logic             pin7_oe,
	output logic             irq
);

	// ==========================================================
	// Bus decode.
	logic        acc;
	logic        wr;
	logic        rd;
	logic        hit_baud;
	logic        hit_ctrl;
	logic        hit_stat;
	logic        hit_data;
	logic        hit_port;
	logic        mapped;

	// Every access completes in its first access cycle.
	assign acc      = psel & penable;
	assign wr       = acc & pwrite;
	assign rd       = acc & ~pwrite;
	assign hit_baud = (paddr == asstx_pkg::ADDR_BAUD);
	assign hit_ctrl = (paddr == asstx_pkg::ADDR_CTRL);
	assign hit_stat = (paddr == asstx_pkg::ADDR_STATUS);
	assign hit_data = (paddr == asstx_pkg::ADDR_DATA);
	assign hit_port = (paddr == asstx_pkg::ADDR_PORT);
	assign mapped   = hit_baud | hit_ctrl | hit_stat | hit_data | hit_port;
	assign pready   = 1'b1;
	assign pslverr  = acc & ~mapped;

	// ==========================================================
	// Software registers.
	logic [12:0] baud_q;
	logic [10:0] ctrl_q;
	logic [1:0]  port_q;
	logic [8:0]  txh_q;
	logic [8:0]  rxh_q;
	logic [6:0]  st_q;
	logic [6:0]  armed_q;
	logic [31:0] prdata_q;

	// Writes honour byte strobes; the baud field spans two lanes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_q <= asstx_pkg::BAUD_RESET;
			ctrl_q <= 11'h000;
			port_q <= 2'h0;
		end else if (wr) begin
			if (hit_baud && pstrb[0])
				baud_q[7:0] <= pwdata[7:0];
			if (hit_baud && pstrb[1])
				baud_q[12:8] <= pwdata[12:8];
			if (hit_ctrl && pstrb[0])
				ctrl_q[7:0] <= pwdata[7:0];
			if (hit_ctrl && pstrb[1])
				ctrl_q[10:8] <= pwdata[10:8];
			if (hit_port && pstrb[0])
				port_q <= pwdata[1:0];
		end
	end

	logic tx_en;
	logic len11;
	logic par_en;
	logic par_odd;
	assign tx_en   = ctrl_q[asstx_pkg::CTRL_TX_EN];
	assign len11   = ctrl_q[asstx_pkg::CTRL_LEN];
	assign par_en  = ctrl_q[asstx_pkg::CTRL_PE];
	assign par_odd = ctrl_q[asstx_pkg::CTRL_PODD];

	// Data bits carried: 8, 7+p, 9, 8+p for len/parity 00,01,10,11.
	logic [3:0] nbits;
	assign nbits = len11 ? 4'h9 : 4'h8;

	// ==========================================================
	// Baud tick: 16 ticks per bit time.
	logic [12:0] bcnt_q;
	logic        tick;
	assign tick = (bcnt_q == 13'h0000);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bcnt_q <= 13'h0000;
		else
			bcnt_q <= tick ? baud_q : bcnt_q - 13'h0001;
	end

	// ==========================================================
	// Flag clearing sequence.
	// Status reads arm exactly the flags that the read returned, taken
	// from the word captured in setup. A later data access clears only
	// armed flags, so a flag that sets after the read survives.
	logic stat_rd;
	logic data_rd;
	logic data_wr;
	logic [6:0] clr;
	assign stat_rd = rd & hit_stat & (|pstrb | 1'b1);
	assign data_rd = rd & hit_data;
	assign data_wr = wr & hit_data;
	// Reads of data clear receive flags only; writes clear TC and empty only.
	assign clr = (data_rd ? (armed_q & asstx_pkg::ST_RX_MASK) : 7'h00) |
		(data_wr ? (armed_q & ~asstx_pkg::ST_RX_MASK) : 7'h00);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			armed_q <= 7'h00;
		else if (stat_rd)
			armed_q <= prdata_q[6:0];
		else if (data_rd | data_wr)
			armed_q <= 7'h00;
	end

	// A write lands while a word still waits (it overwrites) or after a
	// status read showed the empty flag set. Any other write is dropped,
	// so the shifter never picks up a stale holding word.
	logic tx_accept;
	assign tx_accept = data_wr &
		(~st_q[asstx_pkg::ST_TX_HOLDING_EMPTY] | armed_q[asstx_pkg::ST_TX_HOLDING_EMPTY]);

	// ==========================================================
	// Transmitter.
	asstx_pkg::asstx_tx_state_t txs_q;
	logic [10:0] tsh_q;
	logic [3:0]  tbit_q;
	logic [3:0]  tsub_q;
	logic        txd;
	logic        tx_load;
	logic        tpar;
	logic [3:0]  tlen;
	logic [8:0]  tx_word;

	// Holding empty is clear while data waits, so it loads next.
	assign tx_load = (txs_q == asstx_pkg::ASSTX_TX_IDLE) & tick &
		~st_q[asstx_pkg::ST_TX_HOLDING_EMPTY] & tx_en;
	assign tpar = par_odd ^ (len11 ? ^txh_q[7:0] : ^txh_q[6:0]);
	assign tlen = nbits + 4'h2;
	// Ten-bit frames put their stop bit in the top word position.
	assign tx_word = len11 ? (par_en ? {tpar, txh_q[7:0]} : txh_q) :
		{1'b1, par_en ? {tpar, txh_q[6:0]} : txh_q[7:0]};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txs_q  <= asstx_pkg::ASSTX_TX_IDLE;
			tsh_q  <= 11'h7FF;
			tbit_q <= 4'h0;
			tsub_q <= 4'h0;
		end else begin
			unique case (txs_q)
			asstx_pkg::ASSTX_TX_IDLE: begin
				tsh_q <= 11'h7FF;
				if (tx_load) begin
					// Start bit low, data LSB first, stop high.
					tsh_q <= {1'b1, tx_word, 1'b0};
					tbit_q <= 4'h0;
					tsub_q <= 4'h0;
					txs_q  <= asstx_pkg::ASSTX_TX_SHIFT;
				end
			end
			asstx_pkg::ASSTX_TX_SHIFT: begin
				if (tick) begin
					tsub_q <= tsub_q + 4'h1;
					if (tsub_q == asstx_pkg::OVERSAMPLE) begin
						tsh_q  <= {1'b1, tsh_q[10:1]};
						tbit_q <= tbit_q + 4'h1;
						if (tbit_q == tlen - 4'h1)
							txs_q <= asstx_pkg::ASSTX_TX_IDLE;
					end
				end
			end
			default: txs_q <= asstx_pkg::ASSTX_TX_IDLE;
			endcase
		end
	end

	// Break control holds txd low, with no stop bit, for as long as the break bit is set.
	assign txd = tsh_q[0] & ~ctrl_q[asstx_pkg::CTRL_BRK];

	// Transmit holding register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			txh_q <= 9'h000;
		else if (tx_accept)
			txh_q <= len11 ? pwdata[8:0] : {1'b0, pwdata[7:0]};
	end

	// ==========================================================
	// Pin 7 ownership and drive.
	logic serial_owns;
	logic pin_lvl;
	logic pin_out;
	assign serial_owns = tx_en | (txs_q == asstx_pkg::ASSTX_TX_SHIFT);
	assign pin_lvl = serial_owns ? txd : port_q[asstx_pkg::PORT_DOUT];
	assign pin_out = tx_en | port_q[asstx_pkg::PORT_DIR];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin7_o  <= 1'b1;
			pin7_oe <= 1'b0;
		end else begin
			pin7_o <= pin_lvl;
			// Open drain only pulls low; the high level is external.
			pin7_oe <= pin_out & (~ctrl_q[asstx_pkg::CTRL_OD] | ~pin_lvl);
		end
	end

	// ==========================================================
	// Receiver.
	asstx_pkg::asstx_rx_state_t rxs_q;
	logic [1:0]  ones_q;
	logic        rx_prev_q;
	logic [3:0]  rsub_q;
	logic [3:0]  rbit_q;
	logic [9:0]  rsh_q;
	logic [3:0]  idle_q;
	logic        rx_done;
	logic        rx_en;
	logic        mid;
	logic [8:0]  rdat;
	logic        rperr;
	assign rx_en = ctrl_q[asstx_pkg::CTRL_RX_EN];
	assign mid   = tick & (rsub_q == asstx_pkg::MID_SAMPLE);
	assign rx_done = (rxs_q == asstx_pkg::ASSTX_RX_DATA) & mid &
		(rbit_q == nbits);
	// Nine bits shifted in from the top sit in [9:1], eight in [9:2].
	assign rdat  = len11 ? rsh_q[9:1] : {1'b0, rsh_q[9:2]};
	assign rperr = par_en & (par_odd ^ (len11 ? ^rsh_q[9:1]
		: ^rsh_q[9:2]));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxs_q     <= asstx_pkg::ASSTX_RX_HUNT;
			ones_q    <= 2'h0;
			rx_prev_q <= 1'b1;
			rsub_q    <= 4'h0;
			rbit_q    <= 4'h0;
			rsh_q     <= 10'h000;
		end else if (tick) begin
			rx_prev_q <= rxd;
			rsub_q    <= rsub_q + 4'h1;
			unique case (rxs_q)
			asstx_pkg::ASSTX_RX_HUNT: begin
				if (rxd && ones_q != asstx_pkg::START_ONES)
					ones_q <= ones_q + 2'h1;
				// Fall after three one samples marks a start.
				if (rx_en && !rxd && rx_prev_q &&
				    ones_q == asstx_pkg::START_ONES) begin
					rxs_q  <= asstx_pkg::ASSTX_RX_START;
					rsub_q <= 4'h1;
				end
				if (!rxd)
					ones_q <= 2'h0;
			end
			asstx_pkg::ASSTX_RX_START: begin
				if (rsub_q == asstx_pkg::MID_SAMPLE) begin
					rbit_q <= 4'h0;
					rxs_q  <= rxd ? asstx_pkg::ASSTX_RX_HUNT
					              : asstx_pkg::ASSTX_RX_DATA;
				end
			end
			asstx_pkg::ASSTX_RX_DATA: begin
				if (rsub_q == asstx_pkg::MID_SAMPLE) begin
					rbit_q <= rbit_q + 4'h1;
					if (rbit_q != nbits)
						rsh_q <= {rxd, rsh_q[9:1]};
					else begin
						rxs_q  <= asstx_pkg::ASSTX_RX_HUNT;
						ones_q <= 2'h0;
					end
				end
			end
			default: rxs_q <= asstx_pkg::ASSTX_RX_HUNT;
			endcase
		end
	end

	// Idle line: a full frame time of ones while hunting.
	logic idle_set;
	assign idle_set = tick & (rxs_q == asstx_pkg::ASSTX_RX_HUNT) & rxd &
		(rsub_q == asstx_pkg::OVERSAMPLE) & (idle_q == tlen);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			idle_q <= 4'h0;
		else if (!rxd || rxs_q != asstx_pkg::ASSTX_RX_HUNT)
			idle_q <= 4'h0;
		else if (tick && rsub_q == asstx_pkg::OVERSAMPLE && idle_q != 4'hF)
			idle_q <= idle_q + 4'h1;
	end

	// Receive holding register; an unread word is not overwritten.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rxh_q <= 9'h000;
		else if (rx_done && !st_q[asstx_pkg::ST_RX_HOLDING_FULL])
			rxh_q <= rdat;
	end

	// ==========================================================
	// Status flags: set wins over clear.
	logic [6:0] set;
	assign set[asstx_pkg::ST_PF]   = rx_done & rperr;
	assign set[asstx_pkg::ST_FE]   = rx_done & ~rxd;
	assign set[asstx_pkg::ST_OR]   = rx_done & st_q[asstx_pkg::ST_RX_HOLDING_FULL];
	assign set[asstx_pkg::ST_IDLE] = idle_set;
	assign set[asstx_pkg::ST_RX_HOLDING_FULL] = rx_done;
	assign set[asstx_pkg::ST_TC]   = (txs_q == asstx_pkg::ASSTX_TX_SHIFT) &
		tick & (tsub_q == asstx_pkg::OVERSAMPLE) & (tbit_q == tlen - 4'h1) &
		st_q[asstx_pkg::ST_TX_HOLDING_EMPTY];
	assign set[asstx_pkg::ST_TX_HOLDING_EMPTY] = tx_load;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st_q <= 7'h60;
		else begin
			st_q <= (st_q & ~clr) | set;
			if (tx_load)
				st_q[asstx_pkg::ST_TC] <= 1'b0;
		end
	end

	// ==========================================================
	// Read data mux, registered into prdata.
	logic [31:0] rmux;
	assign rmux = hit_baud ? {19'h0_0000, baud_q} :
		hit_ctrl ? {21'h00_0000, ctrl_q} :
		hit_stat ? {25'h000_0000, st_q} :
		hit_data ? {23'h00_0000, rxh_q} :
		hit_port ? {29'h0000_0000, pin7_i, port_q} : 32'h0000_0000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_q <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata_q <= rmux;
	end
	assign prdata = prdata_q;

	// Interrupt request: four enables gate four flags.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= (st_q[asstx_pkg::ST_TX_HOLDING_EMPTY] & ctrl_q[asstx_pkg::CTRL_TIE]) |
				(st_q[asstx_pkg::ST_TC] & ctrl_q[asstx_pkg::CTRL_TX_DONE_IRQ_EN]) |
				(st_q[asstx_pkg::ST_RX_HOLDING_FULL] & ctrl_q[asstx_pkg::CTRL_RIE]) |
				(st_q[asstx_pkg::ST_IDLE] & ctrl_q[asstx_pkg::CTRL_LIE]);
	end

endmodule : asstx_core

// [dv/asstx_checker.sv]
// Checker for the serial core: port-level relations on APB, pin 7 and irq.
// Assumes full-word APB writes and a single pclk domain.
`timescale 1ns/10ps
module asstx_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        pin7_o,
	input wire logic        pin7_oe,
	input wire logic        irq
);
	logic [10:0] ctrl_q;
	logic        acc;
	logic        rd_acc;
	logic        mapped;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Completed transfers and the word-aligned register map.
	assign acc    = psel && penable && pready;
	assign rd_acc = acc && !pwrite;
	assign mapped = paddr[1:0] == 2'h0 && paddr <= asstx_pkg::ADDR_PORT;
	// Shadow of the control word, so pin and irq rules know the mode.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= '0;
		end else if (acc && pwrite && paddr == asstx_pkg::ADDR_CTRL) begin
			ctrl_q <= pwdata[10:0];
		end
	end
	// ==========================================================
	// Properties.
	property p_unmapped;
		acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0);
	endproperty
	property p_mapped;
		acc && mapped |-> !pslverr;
	endproperty
	property p_tx_owns_pin;
		$stable(ctrl_q) && ctrl_q[1] && !ctrl_q[9] |-> pin7_oe;
	endproperty
	property p_open_drain;
		$stable(ctrl_q) && ctrl_q[9] && pin7_oe |-> !pin7_o;
	endproperty
	property p_irq_masked;
		$stable(ctrl_q) && ctrl_q[5:2] == 4'h0 |-> !irq;
	endproperty
	property p_irq_empty;
		rd_acc && paddr == asstx_pkg::ADDR_STATUS && prdata[6]
			&& ctrl_q[5] && $stable(ctrl_q) |-> irq;
	endproperty
	property p_status_width;
		rd_acc && paddr == asstx_pkg::ADDR_STATUS |-> prdata[31:7] == '0;
	endproperty
	property p_data_width;
		rd_acc && paddr == asstx_pkg::ADDR_DATA |-> prdata[31:9] == '0;
	endproperty
	property p_ctrl_back;
		rd_acc && paddr == asstx_pkg::ADDR_CTRL |-> prdata[10:0] == ctrl_q;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("Unmapped access was not refused.");
	a_mapped: assert property (p_mapped)
		else $error("Mapped access was refused.");
	a_tx_owns_pin: assert property (p_tx_owns_pin)
		else $error("Enabled transmitter does not drive pin 7.");
	a_open_drain: assert property (p_open_drain)
		else $error("Open-drain pin driven high.");
	a_irq_masked: assert property (p_irq_masked)
		else $error("Interrupt raised with all enables clear.");
	a_irq_empty: assert property (p_irq_empty)
		else $error("Enabled empty flag gave no interrupt.");
	a_status_width: assert property (p_status_width)
		else $error("Status read has stray upper bits.");
	a_data_width: assert property (p_data_width)
		else $error("Data read wider than nine bits.");
	a_ctrl_back: assert property (p_ctrl_back)
		else $error("Control read differs from last write.");
	c_rx_full: cover property (rd_acc && paddr == asstx_pkg::ADDR_STATUS
		&& prdata[4]);
	c_od: cover property (ctrl_q[9] && pin7_oe);
	c_err: cover property (acc && pslverr);
endmodule : asstx_checker

bind asstx_core asstx_checker i_asstx_checker (
	.pclk    (pclk),
	.presetn (presetn),
	.psel    (psel),
	.penable (penable),
	.pwrite  (pwrite),
	.paddr   (paddr),
	.pwdata  (pwdata),
	.prdata  (prdata),
	.pready  (pready),
	.pslverr (pslverr),
	.pin7_o  (pin7_o),
	.pin7_oe (pin7_oe),
	.irq     (irq)
);

// [dv/asstx_remote.sv]
// Remote serial device: decodes frames seen on pin 7, sends frames on rxd.
// Assumes the core's baud field is zero, so one bit is sixteen clocks.
`timescale 1ns/10ps
module asstx_remote #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic       pclk,
	input  wire logic       line,
	input  wire logic [3:0] nbits,
	output logic            rxd
);
	int q[$];
	// ==========================================================
	// Receiver: mid-bit sampling, bad stop bit is queued as -1.
	initial begin : rx_loop
		int v;
		forever begin
			@(negedge line);
			repeat (BIT_CLKS / 2) @(posedge pclk);
			if (line === 1'b0) begin
				v = 0;
				for (int i = 0; i < nbits; i++) begin
					repeat (BIT_CLKS) @(posedge pclk);
					v = v | (int'(line) << i);
				end
				repeat (BIT_CLKS) @(posedge pclk);
				q.push_back(line === 1'b1 ? v : -1);
			end
		end
	end
	// Line idles high, which is an idle frame of ones.
	initial rxd = 1'b1;
	// Sender: gap of idle ones, start, data LSB first, one stop bit.
	task automatic send(input int v, input int n, input int gap);
		repeat (gap + 1) @(posedge pclk);
		rxd <= 1'b0;
		for (int i = 0; i <= n; i++) begin
			repeat (BIT_CLKS) @(posedge pclk);
			rxd <= (i < n) ? v[i] : 1'b1;
		end
		repeat (BIT_CLKS) @(posedge pclk);
	endtask : send
endmodule : asstx_remote

// [dv/asstx_core_tb_top.sv]
// Testbench: APB master, reference frame model and scoreboard for the core.
// Assumes the remote model on pin 7 and a pull-up on that line.
`timescale 1ns/10ps
module asstx_core_tb_top;
	localparam logic [11:0] CTL = asstx_pkg::ADDR_CTRL;
	localparam logic [11:0] ST  = asstx_pkg::ADDR_STATUS;
	localparam logic [11:0] DAT = asstx_pkg::ADDR_DATA;
	localparam logic [11:0] PRT = asstx_pkg::ADDR_PORT;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        rxd, pin7_o, pin7_oe, irq, line, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  nbits;
	int          n_mismatch, checks_done;
	int          dq[$];
	// Pin 7 wire: undriven it floats up to the pull-up level.
	assign line = pin7_oe ? pin7_o : 1'b1;
	asstx_core i_asstx_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxd(rxd), .pin7_i(line), .pin7_o(pin7_o), .pin7_oe(pin7_oe),
		.irq(irq));
	asstx_remote i_asstx_remote (.pclk(pclk), .line(line), .nbits(nbits),
		.rxd(rxd));
	// 200 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// ==========================================================
	// Scoreboard compare, APB transfer, bounded status poll, verdict.
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic poll(input int b);
		int k;
		k = 0;
		do begin
			apb(1'b0, ST, 32'h0);
			k++;
		end while (rd[b] !== 1'b1 && k < 400);
		chk("poll", rd[b], 1);
	endtask : poll
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	// Reference frame: data masked to width, parity in the top position.
	function automatic int fexp(int d, int n, int pe, int odd);
		int m;
		m = d & ((1 << (n - pe)) - 1);
		if (pe != 0) m = m | ((($countones(m) + odd) % 2) << (n - 1));
		return m;
	endfunction : fexp
	// ==========================================================
	// Main sequence.
	initial begin
		int f, d, n, pe, len, bad, ctl, k;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		nbits = 4'h8;
		n_mismatch = 0;
		checks_done = 0;
		void'($urandom(66));
		repeat (4) @(posedge pclk);
		chk("irq_rst", irq, 0);
		chk("oe_rst", pin7_oe, 0);
		presetn <= 1'b1;
		apb(1'b0, ST, 32'h0);
		chk("status_rst", rd[6:5], 2'b11);
		apb(1'b0, 12'h014, 32'h0);
		chk("unmap_err", err, 1);
		$display("test reset done");
		apb(1'b1, PRT, 32'h2);
		repeat (2) @(posedge pclk);
		chk("gpio_oe", pin7_oe, 1);
		apb(1'b0, PRT, 32'h0);
		chk("gpio_in", rd[2], 0);
		apb(1'b1, CTL, 32'h200);
		apb(1'b1, PRT, 32'h3);
		repeat (2) @(posedge pclk);
		chk("od_oe", pin7_oe, 0);
		apb(1'b1, CTL, 32'h0);
		apb(1'b1, asstx_pkg::ADDR_BAUD, 32'h0);
		$display("test gpio done");
		// The GPIO low pulse looks like a start bit to the remote; let it
		// finish that bogus frame before real frames begin.
		repeat (200) @(posedge pclk);
		for (f = 0; f < 4; f++) begin
			len = f >> 1;
			pe = f & 1;
			n = 8 + len;
			ctl = 3 | (pe << 6) | (len << 7) | (len << 8)
				| (f == 2 ? 32 : (f != 0 ? 8 : 0));
			nbits = 4'(n);
			apb(1'b1, CTL, 32'h0);
			apb(1'b1, CTL, 32'(ctl));
			apb(1'b0, CTL, 32'h0);
			chk("ctrl", rd[10:0], 32'(ctl));
			i_asstx_remote.q.delete();
			// Second word waits in holding while the first shifts.
			for (int w = 0; w < 2; w++) begin
				d = $urandom % 512;
				dq.push_back(fexp(d, n, pe, len));
				poll(6);
				apb(1'b1, DAT, 32'(d));
				// First word moves on at once: this unarmed write is dropped.
				if (w == 0)
					apb(1'b1, DAT, 32'(d ^ 511));
			end
			k = 0;
			while (i_asstx_remote.q.size() < 2 && k < 3000) begin
				@(posedge pclk);
				k++;
			end
			repeat (2) chk("tx_frame", i_asstx_remote.q.size() != 0 ?
				i_asstx_remote.q.pop_front() : -1, dq.pop_front());
			poll(5);
			chk("tx_flags", rd[6:5], 2'b11);
			d = $urandom % 512;
			bad = pe & ($urandom % 2);
			apb(1'b0, ST, 32'h0);
			i_asstx_remote.send(fexp(d, n, pe, len) ^ (bad << (n - 1)), n,
				$urandom % 40);
			// Let the stop bit land and the word reach the holding register.
			repeat (40) @(posedge pclk);
			apb(1'b0, DAT, 32'h0);
			apb(1'b0, ST, 32'h0);
			chk("rx_kept", rd[4], 1);
			chk("parity_err", rd[0], bad);
			chk("irq", irq, f != 0);
			apb(1'b0, DAT, 32'h0);
			chk("rx_data", rd & ((1 << (n - pe)) - 1),
				d & ((1 << (n - pe)) - 1));
			apb(1'b0, ST, 32'h0);
			chk("rx_clear", rd[4], 0);
			$display("test format %0d done", f);
		end
		// Break forces the enabled transmit pin low with no stop bit.
		apb(1'b1, CTL, 32'h0000_0402);
		repeat (2) @(posedge pclk);
		chk("break", line, 0);
		$display("test break done");
		tally_and_finish();
	end
	// Watchdog: the run needs well under a tenth of this span.
	initial begin
		repeat (60000) @(posedge pclk);
		n_mismatch++;
		$display("watchdog expired");
		tally_and_finish();
	end
endmodule : asstx_core_tb_top
